// ==== dmst_engine_model.sv ====
// model: channel engine, one event pulse per bench command
// assumes at most one command per cycle
`timescale 1ns/1ps
module dmst_engine_model (
	// clock and command
	input wire logic        clk,
	input wire logic        reset,
	input wire logic        go,
	input wire logic [1:0]  kind,
	input wire logic [2:0]  ch,
	input wire logic [15:0] addr,
	input wire logic [7:0]  pp_en,
	// events
	output dmst_pkg::dmst_event_type ev
);
	always_ff @(posedge clk) begin
		ev <= '0;
		ev.pingpong_en <= pp_en;
		if (!reset) begin
			// unqualified fields keep changing
			ev.xfer_ch <= ~ev.xfer_ch;
			ev.ram_addr <= ~ev.ram_addr;
			if (go) begin
				case (kind)
				2'd0: begin
					{ev.xfer, ev.ram_access} <= 2'b11;
					{ev.xfer_ch, ev.ram_addr} <= {ch, addr};
				end
				2'd1: ev.ram_col[ch] <= 1'b1;
				2'd2: ev.per_col[ch] <= 1'b1;
				default: ev.block_done[ch] <= 1'b1;
				endcase
			end
		end
	end
endmodule : dmst_engine_model

// ==== dmst_pkg.sv ====
// package: constants and types for the dma status block
// assumes one clock domain and a plain register port
package dmst_pkg;
	localparam int unsigned NUM_CH = 8;
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 16;
	localparam logic [3:0] OFS_COLLISION = 4'h0;
	localparam logic [3:0] OFS_ACTIVITY  = 4'h1;
	localparam logic [3:0] OFS_RAM_ADDR  = 4'h2;
	localparam logic [3:0] OFS_IRQ_STAT  = 4'h3;
	localparam logic [3:0] OFS_IRQ_EN    = 4'h4;
	localparam logic [3:0] OFS_IRQ_CLR   = 4'h5;
	localparam logic [3:0] OFS_COL_CLR   = 4'h6;
	localparam int unsigned RAM_COL_POS  = 0;
	localparam int unsigned PER_COL_POS  = 8;
	localparam int unsigned LAST_CH_POS  = 8;
	localparam logic [3:0] LAST_CH_RESET = 4'hF;
	localparam logic [15:0] RAM_ADDR_RESET = 16'h0000;
	// interrupt status bits
	localparam int unsigned IRQ_RAM_COL  = 0;
	localparam int unsigned IRQ_PER_COL  = 1;
	localparam int unsigned IRQ_XFER     = 2;
	localparam int unsigned IRQ_BLOCK    = 3;
	localparam int unsigned IRQ_W        = 4;

	typedef struct packed {
		logic [3:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} dmst_bus_req_type;

	typedef struct packed {
		logic        xfer;
		logic [2:0]  xfer_ch;
		logic        ram_access;
		logic [15:0] ram_addr;
		logic [7:0]  ram_col;
		logic [7:0]  per_col;
		logic [7:0]  block_done;
		logic [7:0]  pingpong_en;
	} dmst_event_type;
endpackage : dmst_pkg

// ==== dmst_status.sv ====
// file: top of dma status block with register port and interrupt
// assumes engine events are one-cycle pulses synchronous to clk
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
module dmst_status (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     reset,
	// register port
	input  wire dmst_pkg::dmst_bus_req_type bus_req,
	output logic [15:0]                   rdata,
	// engine events
	input  wire dmst_pkg::dmst_event_type ev,
	// interrupt
	output logic                          irq
);
	localparam int unsigned NCH = dmst_pkg::NUM_CH;

	logic [NCH-1:0]  ram_col;
	logic [NCH-1:0]  per_col;
	logic [3:0]      last_ch;
	logic [NCH-1:0]  pp_status;
	logic [15:0]     ram_addr_q;
	logic [15:0]     ram_addr_d;
	logic [15:0]     rdata_q;
	logic [15:0]     rdata_d;
	logic [dmst_pkg::IRQ_W-1:0] irq_en_q;
	logic [dmst_pkg::IRQ_W-1:0] irq_en_d;
	logic [dmst_pkg::IRQ_W-1:0] irq_stat;
	logic [dmst_pkg::IRQ_W-1:0] irq_set;
	logic [dmst_pkg::IRQ_W-1:0] irq_clr;

	// decode
	wire wr_col_clr = bus_req.wr && bus_req.addr == dmst_pkg::OFS_COL_CLR;
	wire wr_irq_en  = bus_req.wr && bus_req.addr == dmst_pkg::OFS_IRQ_EN;
	wire wr_irq_clr = bus_req.wr && bus_req.addr == dmst_pkg::OFS_IRQ_CLR;
	// collision register also clears on write-one
	wire wr_col     = bus_req.wr &&
		(bus_req.addr == dmst_pkg::OFS_COLLISION || wr_col_clr);

	wire [NCH-1:0] ram_col_clr = wr_col ?
		bus_req.wdata[dmst_pkg::RAM_COL_POS +: NCH] : '0;
	wire [NCH-1:0] per_col_clr = wr_col ?
		bus_req.wdata[dmst_pkg::PER_COL_POS +: NCH] : '0;

	dmst_sticky #(.W(NCH)) u_ram_col (
		.clk   (clk),
		.reset (reset),
		.set   (ev.ram_col),
		.clr   (ram_col_clr),
		.flags (ram_col)
	);

	dmst_sticky #(.W(NCH)) u_per_col (
		.clk   (clk),
		.reset (reset),
		.set   (ev.per_col),
		.clr   (per_col_clr),
		.flags (per_col)
	);

	dmst_tracker #(.NUM_CH(NCH)) u_track (
		.clk                           (clk),
		.reset                         (reset),
		.xfer                          (ev.xfer),
		.xfer_ch                       (ev.xfer_ch),
		.block_done                    (ev.block_done),
		.pingpong_en                   (ev.pingpong_en),
		.last_active_channel           (last_ch),
		.pingpong_buffer_select_status (pp_status)
	);

	assign ram_addr_d = ev.ram_access ? ev.ram_addr : ram_addr_q;

	// interrupt events
	assign irq_set[dmst_pkg::IRQ_RAM_COL] = |ev.ram_col;
	assign irq_set[dmst_pkg::IRQ_PER_COL] = |ev.per_col;
	assign irq_set[dmst_pkg::IRQ_XFER]    = ev.xfer;
	assign irq_set[dmst_pkg::IRQ_BLOCK]   = |ev.block_done;
	assign irq_clr = wr_irq_clr ?
		bus_req.wdata[dmst_pkg::IRQ_W-1:0] : '0;
	assign irq_en_d = wr_irq_en ?
		bus_req.wdata[dmst_pkg::IRQ_W-1:0] : irq_en_q;

	dmst_sticky #(.W(dmst_pkg::IRQ_W)) u_irq (
		.clk   (clk),
		.reset (reset),
		.set   (irq_set),
		.clr   (irq_clr),
		.flags (irq_stat)
	);

	assign irq = |(irq_stat & irq_en_q);

	// read mux; unused upper bits zero
	always_comb begin
		rdata_d = '0;
		if (bus_req.rd) begin
			unique case (bus_req.addr)
				dmst_pkg::OFS_COLLISION: begin
					rdata_d = {per_col, ram_col};
				end
				dmst_pkg::OFS_ACTIVITY: begin
					rdata_d = {4'h0, last_ch, pp_status};
				end
				dmst_pkg::OFS_RAM_ADDR: begin
					rdata_d = ram_addr_q;
				end
				dmst_pkg::OFS_IRQ_STAT: begin
					rdata_d = {12'h000, irq_stat};
				end
				dmst_pkg::OFS_IRQ_EN: begin
					rdata_d = {12'h000, irq_en_q};
				end
				default: begin
					rdata_d = '0;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			ram_addr_q <= dmst_pkg::RAM_ADDR_RESET;
			irq_en_q   <= '0;
			rdata_q    <= '0;
		end else begin
			ram_addr_q <= ram_addr_d;
			irq_en_q   <= irq_en_d;
			rdata_q    <= rdata_d;
		end
	end

	assign rdata = rdata_q;
endmodule : dmst_status

// ==== dmst_status_checker.sv ====
// checker: port assertions for the dma status block
// assumes one clock and a synchronous reset
`timescale 1ns/1ps
module dmst_status_checker (
	// clock, reset, port
	input wire logic                       clk,
	input wire logic                       reset,
	input wire dmst_pkg::dmst_bus_req_type bus_req,
	input wire logic [15:0]                rdata,
	// events and interrupt
	input wire dmst_pkg::dmst_event_type   ev,
	input wire logic                       irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	wire rd_col = bus_req.rd && bus_req.addr == dmst_pkg::OFS_COLLISION;
	wire rd_act = bus_req.rd && bus_req.addr == dmst_pkg::OFS_ACTIVITY;
	wire rd_ram = bus_req.rd && bus_req.addr == dmst_pkg::OFS_RAM_ADDR;
	wire wr_col = bus_req.wr && bus_req.addr == dmst_pkg::OFS_COLLISION;
	wire wr_en  = bus_req.wr && bus_req.addr == dmst_pkg::OFS_IRQ_EN;
	a_rdata_idle: assert property (!$past(bus_req.rd) |-> rdata == 16'h0)
		else $error("read data not zero");
	a_top_zero: assert property (
		$past(rd_act) |-> rdata[15:12] == 4'h0)
		else $error("unused bits set");
	a_no_resv: assert property (
		$past(rd_act) |-> rdata[11:8] < 4'h8 || rdata[11:8] == 4'hF)
		else $error("reserved channel code");
	a_last_ch: assert property (
		ev.xfer ##1 (rd_act && !ev.xfer) |=>
		rdata[11:8] == {1'b0, $past(ev.xfer_ch, 2)})
		else $error("wrong last channel");
	a_ram_addr: assert property (
		ev.ram_access ##1 (rd_ram && !ev.ram_access) |=>
		rdata == $past(ev.ram_addr, 2))
		else $error("wrong ram address");
	a_ram_col: assert property (
		ev.ram_col != 0 ##1 rd_col |=>
		(rdata[7:0] & $past(ev.ram_col, 2)) == $past(ev.ram_col, 2))
		else $error("ram collision lost");
	a_per_col: assert property (
		ev.per_col != 0 ##1 rd_col |=>
		(rdata[15:8] & $past(ev.per_col, 2)) == $past(ev.per_col, 2))
		else $error("peripheral collision lost");
	a_col_clear: assert property (
		(wr_col && bus_req.wdata == 16'hFFFF && ev.ram_col == 0 &&
		ev.per_col == 0) ##1 rd_col |=> rdata == 16'h0)
		else $error("collision clear failed");
	a_irq_off: assert property (
		(wr_en && bus_req.wdata[3:0] == 4'h0) |=> !irq)
		else $error("irq while disabled");
endmodule : dmst_status_checker
bind dmst_status dmst_status_checker chk_u (.clk(clk), .reset(reset),
	.bus_req(bus_req), .rdata(rdata), .ev(ev), .irq(irq));

// ==== dmst_sticky.sv ====
// file: bank of sticky flags, set by hardware, cleared by mask
// assumes clear and set arrive synchronous to clk
`timescale 1ns/1ps
module dmst_sticky #(
	parameter int unsigned W = 8
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         reset,
	// set and clear
	input  wire logic [W-1:0] set,
	input  wire logic [W-1:0] clr,
	// state
	output logic      [W-1:0] flags
);
	logic [W-1:0] flags_q;
	logic [W-1:0] flags_d;

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			assign flags_d[i] = set[i] | (flags_q[i] & ~clr[i]);
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (reset) begin
			flags_q <= '0;
		end else begin
			flags_q <= flags_d;
		end
	end

	assign flags = flags_q;
endmodule : dmst_sticky

// ==== dmst_tracker.sv ====
// file: last active channel and ping-pong selection tracking
// assumes event strobes are one-cycle pulses from the engine
`timescale 1ns/1ps
module dmst_tracker #(
	parameter int unsigned NUM_CH = 8
) (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              reset,
	// engine events
	input  wire logic              xfer,
	input  wire logic [2:0]        xfer_ch,
	input  wire logic [NUM_CH-1:0] block_done,
	input  wire logic [NUM_CH-1:0] pingpong_en,
	// state
	output logic      [3:0]        last_active_channel,
	output logic      [NUM_CH-1:0] pingpong_buffer_select_status
);
	logic [3:0]        last_q;
	logic [3:0]        last_d;
	logic [NUM_CH-1:0] pp_q;
	logic [NUM_CH-1:0] pp_d;

	assign last_d = xfer ? {1'b0, xfer_ch} : last_q;

	genvar i;
	generate
		for (i = 0; i < NUM_CH; i++) begin : g_pp
			assign pp_d[i] = pp_q[i] ^ (block_done[i] & pingpong_en[i]);
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (reset) begin
			last_q <= dmst_pkg::LAST_CH_RESET;
			pp_q   <= '0;
		end else begin
			last_q <= last_d;
			pp_q   <= pp_d;
		end
	end

	assign last_active_channel           = last_q;
	assign pingpong_buffer_select_status = pp_q;
endmodule : dmst_tracker

// ==== test_dmst_status.sv ====
// testbench: dma status block, random events and register reads
// assumes the engine model drives the event port
`timescale 1ns/1ps
module test_dmst_status;
	logic clk = 0, reset = 1, go = 0, rd_d = 0, irq;
	logic [1:0] kind = 0;
	logic [2:0] ch = 0;
	logic [7:0] pe = 0, pp = 0;
	logic [3:0] last = 4'hF;
	logic [15:0] addr = 0, col = 0, ram = 0, rdata;
	logic [31:0] r;
	logic [15:0] exp_q[$];
	int miscompares = 0, samples_checked = 0;
	dmst_pkg::dmst_bus_req_type bus_req = '0;
	dmst_pkg::dmst_event_type ev;
	initial forever #5 clk = ~clk;
	dmst_engine_model eng_u (.clk(clk), .reset(reset), .go(go), .kind(kind),
		.ch(ch), .addr(addr), .pp_en(pe), .ev(ev));
	dmst_status dut_u (.clk(clk), .reset(reset), .bus_req(bus_req),
		.rdata(rdata), .ev(ev), .irq(irq));
	task chk(input logic [15:0] s, input logic [15:0] e);
		samples_checked++;
		if (s !== e) begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, s, e);
		end
	endtask : chk
	task wr(input logic [3:0] a, input logic [15:0] v);
		bus_req <= '{a, v, 1'b1, 1'b0};
		go <= 0;
		@(posedge clk);
	endtask : wr
	task rd(input logic [3:0] a, input logic [15:0] e);
		bus_req <= '{a, 16'h0, 1'b0, 1'b1};
		go <= 0;
		exp_q.push_back(e);
		@(posedge clk);
	endtask : rd
	task idle;
		bus_req <= '0;
		go <= 0;
		@(posedge clk);
		#1;
	endtask : idle
	task evt(input logic [1:0] k, input logic [2:0] c, input logic [15:0] a,
		input logic [7:0] p);
		bus_req <= '0;
		{go, kind, ch, addr, pe} <= {1'b1, k, c, a, p};
		@(posedge clk);
		case (k)
		2'd0: {last, ram} = {1'b0, c, a};
		2'd1: col[c] = 1'b1;
		2'd2: col[8+c] = 1'b1;
		default: pp[c] = pp[c] ^ p[c];
		endcase
	endtask : evt
	task finish_test;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : finish_test
	// read reply lands the cycle after the strobe
	always @(posedge clk) begin
		if (rd_d) chk(rdata, exp_q.pop_front());
		rd_d <= bus_req.rd;
	end
	initial begin
		#300000;
		miscompares++;
		finish_test;
	end
	initial begin
		void'($urandom(32'h8354));
		repeat (12) @(posedge clk);
		reset <= 0;
		rd(4'h0, 16'h0000);
		rd(4'h1, 16'h0F00);
		rd(4'h2, 16'h0000);
		rd(4'hF, 16'h0000);
		idle;
		$display("test reset done");
		repeat (60) begin
			r = $urandom;
			evt(r[1:0], r[4:2], r[31:16], r[12:5]);
			idle;
			rd(4'h0, col);
			r = $urandom;
			wr(r[0] ? 4'h0 : 4'h6, r[31:16]);
			col = col & ~r[31:16];
			rd(4'h0, col);
			wr(4'h1, r[15:0]);
			rd(4'h1, {4'h0, last, pp});
			rd(4'h2, ram);
		end
		idle;
		r = $urandom;
		evt(2'd0, r[2:0], r[31:16], 8'h00);
		idle;
		rd(4'h1, {4'h0, last, pp});
		evt(2'd0, r[5:3], r[15:0], 8'h00);
		idle;
		rd(4'h2, ram);
		$display("test random done");
		wr(4'h5, 16'h000F);
		wr(4'h4, 16'h0001);
		idle;
		chk({15'h0, irq}, 16'h0000);
		evt(2'd1, 3'd0, 16'h0000, 8'h00);
		idle;
		chk({15'h0, irq}, 16'h0001);
		rd(4'h3, 16'h0001);
		wr(4'h4, 16'h0000);
		idle;
		chk({15'h0, irq}, 16'h0000);
		wr(4'h4, 16'h0001);
		idle;
		chk({15'h0, irq}, 16'h0001);
		wr(4'h5, 16'h0001);
		idle;
		chk({15'h0, irq}, 16'h0000);
		wr(4'h0, 16'hFFFF);
		rd(4'h0, 16'h0000);
		idle;
		$display("test irq done");
		reset <= 1;
		bus_req <= '0;
		go <= 0;
		repeat (3) @(posedge clk);
		reset <= 0;
		{last, pp, col, ram} = {4'hF, 8'h00, 16'h0000, 16'h0000};
		rd(4'h1, 16'h0F00);
		rd(4'h0, 16'h0000);
		rd(4'h2, 16'h0000);
		evt(2'd2, 3'd1, 16'h0000, 8'h00);
		evt(2'd3, 3'd2, 16'h0000, 8'h04);
		evt(2'd0, 3'd3, 16'h1234, 8'h00);
		idle;
		rd(4'h1, {4'h0, last, pp});
		rd(4'h0, col);
		rd(4'h3, 16'h000E);
		wr(4'h4, 16'h0008);
		idle;
		chk({15'h0, irq}, 16'h0001);
		$display("test reset again done");
		repeat (2) @(posedge clk);
		finish_test;
	end
endmodule : test_dmst_status
